/* lct_txrx_control.sv */
/*
 * Twelve-channel transmit/receive control bank with APB access, loss
 * declaration per channel and the per-channel link logic.
 * Assumes an APB master, raw detector levels from the analog front end
 * and per-channel line and recovered clocks unrelated to clock_in.
 */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "lct_defs.svh"

module lct_txrx_control
	import lct_pkg::*;
(
	input  wire logic                       clock_in,
	input  wire logic                       rst_n_in,
	input  wire logic                       psel_in,
	input  wire logic                       penable_in,
	input  wire logic                       pwrite_in,
	input  wire logic [`LCT_ADDR_W-1:0]     paddr_in,
	input  wire logic [`LCT_DATA_W-1:0]     pwdata_in,
	output logic      [`LCT_DATA_W-1:0]     prdata_out,
	output logic                            pready_out,
	output logic                            pslverr_out,
	input  wire logic [`LCT_NUM_CHAN-1:0]   tx_line_clock_in,
	input  wire logic [`LCT_NUM_CHAN-1:0]   tx_positive_rail_in,
	input  wire logic [`LCT_NUM_CHAN-1:0]   tx_negative_rail_in,
	output logic      [`LCT_NUM_CHAN-1:0]   tx_line_pos_out,
	output logic      [`LCT_NUM_CHAN-1:0]   tx_line_neg_out,
	output logic      [`LCT_NUM_CHAN-1:0]   tx_build_out_long_out,
	input  wire logic [`LCT_NUM_CHAN-1:0]   rx_recovered_clock_in,
	input  wire logic [`LCT_NUM_CHAN-1:0]   rx_data_pos_in,
	input  wire logic [`LCT_NUM_CHAN-1:0]   rx_data_neg_in,
	output logic      [`LCT_NUM_CHAN-1:0]   rx_positive_rail_out,
	output logic      [`LCT_NUM_CHAN-1:0]   rx_negative_rail_out,
	output logic      [`LCT_NUM_CHAN-1:0]   rx_equalizer_enable_out,
	input  wire logic [`LCT_NUM_CHAN-1:0]   analog_los_raw_in,
	input  wire logic [`LCT_NUM_CHAN-1:0]   digital_los_raw_in,
	output logic      [`LCT_NUM_CHAN-1:0]   los_declared_out
);

	// decoded access: which channel, which register, is it mapped
	typedef struct packed {
		logic       hit;
		logic [3:0] chan;
		logic [3:0] reg_sel;
	} lct_decode_type;

	lct_tx_cfg_type                tx_cfg_reg [`LCT_NUM_CHAN];
	lct_rx_cfg_type                rx_cfg_reg [`LCT_NUM_CHAN];
	logic [`LCT_NUM_CHAN-1:0]      e3_mode_reg;
	logic [`LCT_NUM_CHAN-1:0]      analog_signal_loss_detector_meta_reg;
	logic [`LCT_NUM_CHAN-1:0]      analog_signal_loss_detector_sync_reg;
	logic [`LCT_NUM_CHAN-1:0]      digital_signal_loss_detector_meta_reg;
	logic [`LCT_NUM_CHAN-1:0]      digital_signal_loss_detector_sync_reg;
	logic [`LCT_NUM_CHAN-1:0]      los_reg;
	logic [`LCT_NUM_CHAN-1:0]      los_next;
	logic [`LCT_DATA_W-1:0]        rdata_reg;
	logic [`LCT_DATA_W-1:0]        rdata_next;
	logic                          err_reg;
	lct_decode_type                dec;
	logic                          setup_phase;
	logic                          write_strobe;

	// register index from a byte address; channel nibble 0-5 and 8-d
	function automatic lct_decode_type lct_decode(
		input logic [`LCT_ADDR_W-1:0] addr
	);
		lct_decode_type d;
		logic [7:0]     idx;
		d   = '0;
		idx = addr[9:2];
		d.reg_sel = idx[3:0];
		if (idx[7:4] <= 4'h5) begin
			d.chan = idx[7:4];
			d.hit  = 1'b1;
		end else if (idx[7:4] >= 4'h8 && idx[7:4] <= 4'hd) begin
			d.chan = idx[7:4] - 4'h2;
			d.hit  = 1'b1;
		end
		if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0) begin
			d.hit = 1'b0;
		end
		if (d.reg_sel < `LCT_IDX_TX_CTRL || d.reg_sel > `LCT_IDX_STATUS) begin
			d.hit = 1'b0;
		end
		return d;
	endfunction

	// a detector is running unless disabled outside E3 mode
	function automatic logic lct_detector_on(
		input logic off_bit,
		input logic e3
	);
		return !(off_bit && !e3);
	endfunction

	assign dec          = lct_decode(paddr_in);
	assign setup_phase  = psel_in && !penable_in;
	assign write_strobe = psel_in && penable_in && pwrite_in && dec.hit;

	// zero wait states; read data was prepared during setup
	assign pready_out  = 1'b1;
	assign pslverr_out = err_reg;
	assign prdata_out  = rdata_reg;

	// transmit register, one channel per write
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < `LCT_NUM_CHAN; i++) begin
				tx_cfg_reg[i] <= '0;
			end
		end else if (write_strobe && dec.reg_sel == `LCT_IDX_TX_CTRL) begin
			tx_cfg_reg[dec.chan] <= {
				pwdata_in[`LCT_TX_TRANSMIT_ALL_ONES_SELECT_BIT],
				pwdata_in[`LCT_TX_EDGE_BIT],
				pwdata_in[`LCT_TX_LEV_BIT]};
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < `LCT_NUM_CHAN; i++) begin
				rx_cfg_reg[i] <= '0;
			end
		end else if (write_strobe && dec.reg_sel == `LCT_IDX_RX_CTRL) begin
			rx_cfg_reg[dec.chan] <= {
				pwdata_in[`LCT_RX_DIGITAL_SIGNAL_LOSS_DETECTOR_BIT],
				pwdata_in[`LCT_RX_ANALOG_SIGNAL_LOSS_DETECTOR_BIT],
				pwdata_in[`LCT_RX_EDGE_BIT],
				pwdata_in[`LCT_RX_MUTE_BIT],
				pwdata_in[`LCT_RX_MON_BIT],
				pwdata_in[`LCT_RX_EQ_BIT]};
		end
	end

	// line-rate mode: E3 when set, DS3/STS-1 when clear
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			e3_mode_reg <= '0;
		end else if (write_strobe && dec.reg_sel == `LCT_IDX_MODE) begin
			e3_mode_reg[dec.chan] <= pwdata_in[`LCT_MODE_E3_BIT];
		end
	end

	// raw detector levels come from the front end: two flops each
	always_ff @(posedge clock_in) begin
		analog_signal_loss_detector_meta_reg <= analog_los_raw_in;
		analog_signal_loss_detector_sync_reg <= analog_signal_loss_detector_meta_reg;
		digital_signal_loss_detector_meta_reg <= digital_los_raw_in;
		digital_signal_loss_detector_sync_reg <= digital_signal_loss_detector_meta_reg;
	end

	// loss declaration per channel
	always_comb begin
		los_next = '0;
		for (int i = 0; i < `LCT_NUM_CHAN; i++) begin
			los_next[i] =
				(analog_signal_loss_detector_sync_reg[i] &&
				 lct_detector_on(rx_cfg_reg[i].analog_signal_loss_detector_off, e3_mode_reg[i])) ||
				(digital_signal_loss_detector_sync_reg[i] &&
				 lct_detector_on(rx_cfg_reg[i].digital_signal_loss_detector_off, e3_mode_reg[i]));
			if (rx_cfg_reg[i].monitor) begin
				los_next[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			los_reg <= '0;
		end else begin
			los_reg <= los_next;
		end
	end

	assign los_declared_out = los_reg;

	// read data and error prepared in the setup cycle
	always_comb begin
		rdata_next = '0;
		case (dec.reg_sel)
			`LCT_IDX_TX_CTRL: begin
				rdata_next[`LCT_TX_TRANSMIT_ALL_ONES_SELECT_BIT] = tx_cfg_reg[dec.chan].all_ones;
				rdata_next[`LCT_TX_EDGE_BIT] = tx_cfg_reg[dec.chan].sample_rise;
				rdata_next[`LCT_TX_LEV_BIT]  = tx_cfg_reg[dec.chan].build_out;
			end
			`LCT_IDX_RX_CTRL: begin
				rdata_next[5:0] = rx_cfg_reg[dec.chan];
			end
			`LCT_IDX_MODE: begin
				rdata_next[`LCT_MODE_E3_BIT] = e3_mode_reg[dec.chan];
			end
			`LCT_IDX_STATUS: begin
				rdata_next[`LCT_STAT_LOS_BIT] = los_reg[dec.chan];
			end
			default: begin
				rdata_next = '0;
			end
		endcase
		if (!dec.hit) begin
			rdata_next = '0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			rdata_reg <= '0;
			err_reg   <= 1'b0;
		end else if (setup_phase) begin
			rdata_reg <= pwrite_in ? '0 : rdata_next;
			// status is read-only, so writing it is refused too
			err_reg   <= !dec.hit ||
				(pwrite_in && dec.reg_sel == `LCT_IDX_STATUS);
		end
	end

	// per-channel link logic and build-out control
	for (genvar c = 0; c < `LCT_NUM_CHAN; c++) begin : g_chan
		lct_link_cfg_type link_cfg;

		assign link_cfg.all_ones    = tx_cfg_reg[c].all_ones;
		assign link_cfg.sample_rise = tx_cfg_reg[c].sample_rise;
		assign link_cfg.out_fall    = rx_cfg_reg[c].out_fall;
		assign link_cfg.mute_now    = rx_cfg_reg[c].mute && los_reg[c];

		assign tx_build_out_long_out[c] = tx_cfg_reg[c].build_out &&
			!e3_mode_reg[c];
		assign rx_equalizer_enable_out[c] = rx_cfg_reg[c].equalizer;

		lct_chan_link u_link (
			.rst_n_in             (rst_n_in),
			.cfg_in               (link_cfg),
			.tx_line_clock_in     (tx_line_clock_in[c]),
			.tx_positive_rail_in  (tx_positive_rail_in[c]),
			.tx_negative_rail_in  (tx_negative_rail_in[c]),
			.rx_clock_in          (rx_recovered_clock_in[c]),
			.rx_pos_in            (rx_data_pos_in[c]),
			.rx_neg_in            (rx_data_neg_in[c]),
			.tx_line_pos_out      (tx_line_pos_out[c]),
			.tx_line_neg_out      (tx_line_neg_out[c]),
			.rx_positive_rail_out (rx_positive_rail_out[c]),
			.rx_negative_rail_out (rx_negative_rail_out[c])
		);
	end

endmodule

/* lct_defs.svh */
/*
 * Register indices, field positions, reset values and sizes of the
 * per-channel transmit/receive control bank.
 * Assumes an APB slave with 32-bit data, one register per word.
 */
// Functional notes
// - all-ones select set: drop system data, send unframed all-ones pattern
// - sample-edge select: 0 captures rails on falling edge, 1 on rising
// - build-out select ignored in E3 mode, used only in DS3/STS-1
// - receive bit 5 set turns the digital signal-loss detector off
// - receive bit 4 set turns the analog signal-loss detector off
// - both detector-disable bits act only in DS3/STS-1, ignored in E3
// - output-edge select: 0 launches recovered data rising, 1 falling
// - per-channel receive register at 0xm5, m 0-5 and 8-D, bits 7:6 reserved
// - transmit selections held per channel, writes touch one channel only
// - mute bit set forces both recovered outputs low during signal loss
// - monitor mode bit set suppresses signal-loss declaration entirely
`ifndef LCT_DEFS_SVH
`define LCT_DEFS_SVH

`define LCT_NUM_CHAN      12
`define LCT_ADDR_W        12
`define LCT_DATA_W        32

// register index low nibble, channel in the high nibble
`define LCT_IDX_TX_CTRL   4'h4
`define LCT_IDX_RX_CTRL   4'h5
`define LCT_IDX_MODE      4'h6
`define LCT_IDX_STATUS    4'h7

// transmit control fields
`define LCT_TX_TRANSMIT_ALL_ONES_SELECT_BIT   2
`define LCT_TX_EDGE_BIT   1
`define LCT_TX_LEV_BIT    0
`define LCT_TX_MASK       8'h07

// receive control fields
`define LCT_RX_DIGITAL_SIGNAL_LOSS_DETECTOR_BIT   5
`define LCT_RX_ANALOG_SIGNAL_LOSS_DETECTOR_BIT   4
`define LCT_RX_EDGE_BIT   3
`define LCT_RX_MUTE_BIT   2
`define LCT_RX_MON_BIT    1
`define LCT_RX_EQ_BIT     0
`define LCT_RX_MASK       8'h3f

// mode and status fields
`define LCT_MODE_E3_BIT   2
`define LCT_STAT_LOS_BIT  0

`define LCT_RESET_VAL     8'h00

`endif

/* lct_pkg.sv */
/*
 * Types shared by the control bank and its per-channel link logic.
 * Assumes lct_defs.svh supplies all numbers.
 */
package lct_pkg;

	// transmit selections of one channel
	typedef struct packed {
		logic all_ones;
		logic sample_rise;
		logic build_out;
	} lct_tx_cfg_type;

	// receive selections of one channel
	typedef struct packed {
		logic digital_signal_loss_detector_off;
		logic analog_signal_loss_detector_off;
		logic out_fall;
		logic mute;
		logic monitor;
		logic equalizer;
	} lct_rx_cfg_type;

	// settings that the link logic needs, all in the bus domain
	typedef struct packed {
		logic all_ones;
		logic sample_rise;
		logic out_fall;
		logic mute_now;
	} lct_link_cfg_type;

endpackage

/* lct_chan_link.sv */
/*
 * One channel's link logic: dual-rail transmit capture on the line
 * clock and recovered-data launch on the recovered clock.
 * Assumes cfg_in is static-ish bus-domain state; it is resynchronised.
 */
`timescale 1ns/1ps
`include "lct_defs.svh"

module lct_chan_link
	import lct_pkg::*;
(
	input  wire logic             rst_n_in,
	input  wire lct_link_cfg_type cfg_in,
	input  wire logic             tx_line_clock_in,
	input  wire logic             tx_positive_rail_in,
	input  wire logic             tx_negative_rail_in,
	input  wire logic             rx_clock_in,
	input  wire logic             rx_pos_in,
	input  wire logic             rx_neg_in,
	output logic                  tx_line_pos_out,
	output logic                  tx_line_neg_out,
	output logic                  rx_positive_rail_out,
	output logic                  rx_negative_rail_out
);

	logic [2:0] tx_meta_reg;
	logic [2:0] tx_sync_reg;
	logic [2:0] rx_meta_reg;
	logic [2:0] rx_sync_reg;
	logic [1:0] rise_cap_reg;
	logic [1:0] fall_cap_reg;
	logic [1:0] tx_line_reg;
	logic       mark_phase_reg;
	logic [1:0] rx_rise_reg;
	logic [1:0] rx_fall_reg;

	// reset and settings into the transmit domain, two flops each
	always_ff @(posedge tx_line_clock_in) begin
		tx_meta_reg <= {rst_n_in, cfg_in.all_ones, cfg_in.sample_rise};
		tx_sync_reg <= tx_meta_reg;
	end

	always_ff @(posedge tx_line_clock_in) begin
		rise_cap_reg <= {tx_positive_rail_in, tx_negative_rail_in};
	end

	always_ff @(negedge tx_line_clock_in) begin
		fall_cap_reg <= {tx_positive_rail_in, tx_negative_rail_in};
	end

	always_ff @(posedge tx_line_clock_in) begin
		if (!tx_sync_reg[2]) begin
			tx_line_reg    <= 2'h0;
			mark_phase_reg <= 1'b0;
		end else if (tx_sync_reg[1]) begin
			// every bit a mark, alternating polarity
			tx_line_reg    <= {~mark_phase_reg, mark_phase_reg};
			mark_phase_reg <= ~mark_phase_reg;
		end else begin
			tx_line_reg    <= tx_sync_reg[0] ? rise_cap_reg : fall_cap_reg;
			mark_phase_reg <= 1'b0;
		end
	end

	assign tx_line_pos_out = tx_line_reg[1];
	assign tx_line_neg_out = tx_line_reg[0];

	// reset and settings into the recovered-clock domain
	always_ff @(posedge rx_clock_in) begin
		rx_meta_reg <= {rst_n_in, cfg_in.out_fall, cfg_in.mute_now};
		rx_sync_reg <= rx_meta_reg;
	end

	// received data on the rising edge, zero while muted or in reset
	always_ff @(posedge rx_clock_in) begin
		if (!rx_sync_reg[2] || rx_sync_reg[0]) begin
			rx_rise_reg <= 2'h0;
		end else begin
			rx_rise_reg <= {rx_pos_in, rx_neg_in};
		end
	end

	// same data relaunched half a clock later
	always_ff @(negedge rx_clock_in) begin
		rx_fall_reg <= rx_rise_reg;
	end

	assign rx_positive_rail_out = rx_sync_reg[1] ? rx_fall_reg[1]
		: rx_rise_reg[1];
	assign rx_negative_rail_out = rx_sync_reg[1] ? rx_fall_reg[0]
		: rx_rise_reg[0];

endmodule

/* lct_txrx_control_asserts.sv */
/* assertions on the bank's bus, pin and loss ports
   assumes it is bound into lct_txrx_control */
`timescale 1ns/1ps
`include "lct_defs.svh"
module lct_txrx_control_asserts (
	input wire logic                     clock_in,
	input wire logic                     rst_n_in,
	input wire logic                     psel_in,
	input wire logic                     penable_in,
	input wire logic                     pwrite_in,
	input wire logic [`LCT_ADDR_W-1:0]   paddr_in,
	input wire logic [`LCT_DATA_W-1:0]   prdata_out,
	input wire logic                     pslverr_out,
	input wire logic [`LCT_NUM_CHAN-1:0] tx_build_out_long_out,
	input wire logic [`LCT_NUM_CHAN-1:0] rx_equalizer_enable_out,
	input wire logic [`LCT_NUM_CHAN-1:0] analog_los_raw_in,
	input wire logic [`LCT_NUM_CHAN-1:0] digital_los_raw_in,
	input wire logic [`LCT_NUM_CHAN-1:0] los_declared_out
);
	logic [3:0]  m_w;
	logic [3:0]  n_w;
	logic        bad_w;
	logic [23:0] pins_w;
	// decode of the word being accessed
	assign m_w = paddr_in[9:6];
	assign n_w = paddr_in[5:2];
	assign bad_w = (paddr_in[11:10] != 2'h0) || (paddr_in[1:0] != 2'h0) ||
		(m_w[2:1] == 2'h3) || (n_w < 4'h4) || (n_w > 4'h7);
	assign pins_w = {tx_build_out_long_out, rx_equalizer_enable_out};
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	sequence acc_s;
		psel_in && penable_in;
	endsequence
	sequence rd_s;
		acc_s ##0 !pwrite_in;
	endsequence
	reset_clear_a: assert property (disable iff (1'b0) !rst_n_in |=>
		los_declared_out == '0 && tx_build_out_long_out == '0 &&
		rx_equalizer_enable_out == '0) else $error("pins not cleared");
	bad_err_a: assert property (acc_s ##0 bad_w |-> pslverr_out)
		else $error("no error on unmapped access");
	bad_zero_a: assert property (rd_s ##0 bad_w |-> prdata_out == '0)
		else $error("unmapped read not zero");
	good_ok_a: assert property (acc_s ##0 !bad_w &&
		!(pwrite_in && n_w == 4'h7) |-> !pslverr_out)
		else $error("error on mapped access");
	rx_spare_a: assert property (rd_s ##0 !bad_w && n_w == 4'h5 |->
		prdata_out[31:6] == '0) else $error("receive spare bits set");
	tx_spare_a: assert property (rd_s ##0 !bad_w && n_w == 4'h4 |->
		prdata_out[31:3] == '0) else $error("transmit spare bits set");
	los_cause_a: assert property (los_declared_out != '0 |->
		(los_declared_out & ~$past(analog_los_raw_in | digital_los_raw_in,
		3)) == '0) else $error("loss declared without raw loss");
	build_write_a: assert property ($changed(tx_build_out_long_out) |->
		$past(psel_in && penable_in && pwrite_in))
		else $error("build-out moved without write");
	one_chan_a: assert property ($changed(pins_w) |->
		$onehot(pins_w ^ $past(pins_w))) else $error("two channels moved");
endmodule
bind lct_txrx_control lct_txrx_control_asserts u_asserts (
	.clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.prdata_out(prdata_out), .pslverr_out(pslverr_out),
	.tx_build_out_long_out(tx_build_out_long_out),
	.rx_equalizer_enable_out(rx_equalizer_enable_out),
	.analog_los_raw_in(analog_los_raw_in),
	.digital_los_raw_in(digital_los_raw_in),
	.los_declared_out(los_declared_out));

/* lct_far_end.sv */
/* far-end model: terminal equipment feeding transmit rails and the
   recovered receive side; assumes free-running 80 ns line clocks */
`timescale 1ns/1ps
module lct_far_end (
	input  wire logic [11:0] tx_val_in,
	input  wire logic [11:0] rx_val_in,
	output logic      [11:0] line_clock_out,
	output logic      [11:0] tx_pos_out,
	output logic      [11:0] tx_neg_out,
	output logic      [11:0] rx_clock_out,
	output logic      [11:0] rx_pos_out,
	output logic      [11:0] rx_neg_out
);
	logic lclk;
	logic rclk;
	// line clocks, phase unrelated to the bus clock
	initial begin
		lclk = 1'b0;
		tx_pos_out = '0;
		tx_neg_out = '0;
		#3.3;
		forever #40 lclk = ~lclk;
	end
	initial begin
		rclk = 1'b0;
		rx_pos_out = '0;
		rx_neg_out = '0;
		#17.9;
		forever #40 rclk = ~rclk;
	end
	assign line_clock_out = {12{rclk ^ rclk ^ lclk}};
	assign rx_clock_out = {12{rclk}};
	// rails move just after rising edges, never both marks at once
	always @(posedge lclk) begin
		tx_pos_out <= tx_val_in;
		tx_neg_out <= ~tx_val_in;
	end
	always @(posedge rclk) begin
		rx_pos_out <= rx_val_in;
		rx_neg_out <= ~rx_val_in;
	end
endmodule

/* tb_lct_txrx_control.sv */
/* self-checking bench of the control bank: random settings, readback,
   loss, mute and rail checks; assumes lct_far_end as the far side */
`timescale 1ns/1ps
module tb_lct_txrx_control;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr, txv, rxv, analog_signal_loss_detector, digital_signal_loss_detector, p1, p2, n2;
	logic [11:0] tclk, tp, tn, rclk, rp, rn, txp, txn, bld, rxpo, rxno;
	logic [11:0] eq, los;
	logic [31:0] pwdata, prdata, rd, d;
	logic [7:0]  tx_m [12];
	logic [7:0]  rx_m [12];
	logic        e3_m [12];
	logic [11:0] bad_a [5];
	integer      seed, n_fail, num_checks, len;

	lct_far_end FAR (.tx_val_in(txv), .rx_val_in(rxv), .line_clock_out(tclk),
		.tx_pos_out(tp), .tx_neg_out(tn), .rx_clock_out(rclk),
		.rx_pos_out(rp), .rx_neg_out(rn));
	lct_txrx_control DUT (.clock_in(clk), .rst_n_in(rst_n), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .tx_line_clock_in(tclk),
		.tx_positive_rail_in(tp), .tx_negative_rail_in(tn),
		.tx_line_pos_out(txp), .tx_line_neg_out(txn),
		.tx_build_out_long_out(bld), .rx_recovered_clock_in(rclk),
		.rx_data_pos_in(rp), .rx_data_neg_in(rn),
		.rx_positive_rail_out(rxpo), .rx_negative_rail_out(rxno),
		.rx_equalizer_enable_out(eq), .analog_los_raw_in(analog_signal_loss_detector),
		.digital_los_raw_in(digital_signal_loss_detector), .los_declared_out(los));

	// bus clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic results();
		if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %0t reg got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_pin(input logic g, input logic e, input int c);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %0t pin of channel %0d got %b", $time, c, g);
		end
	endtask

	// one bus transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] v);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k == 50) begin
			n_fail++;
			$display("mismatch %0t no bus answer", $time);
			results();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic [11:0] ra(input int c, input logic [3:0] n);
		logic [3:0] m;
		m = (c < 6) ? c[3:0] : c[3:0] + 4'h2;
		return {2'h0, m, n, 2'h0};
	endfunction

	function automatic logic los_exp(input int c);
		logic on_a;
		logic on_d;
		on_a = !(rx_m[c][4] && !e3_m[c]);
		on_d = !(rx_m[c][5] && !e3_m[c]);
		return !rx_m[c][1] && ((analog_signal_loss_detector[c] && on_a) || (digital_signal_loss_detector[c] && on_d));
	endfunction

	// run limit
	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		$display("mismatch %0t run limit reached", $time);
		results();
	end

	initial begin
		seed = 32'hd68e452b;
		n_fail = 0;
		num_checks = 0;
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{txv, rxv, analog_signal_loss_detector, digital_signal_loss_detector} = '0;
		bad_a = '{12'h194, 12'h00c, 12'h814, 12'h015, 12'h01c};
		repeat (34) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int c = 0; c < 12; c++) begin
			apb(1'b0, ra(c, 4'h4), '0);
			chk_reg(rd, '0);
			apb(1'b0, ra(c, 4'h5), '0);
			chk_reg(rd, '0);
		end
		for (int it = 0; it < 6; it++) begin
			for (int c = 0; c < 12; c++) begin
				d = $random(seed);
				len = {$random(seed)} % 450;
				d[0] = (len > 225);
				apb(1'b1, ra(c, 4'h4), d);
				tx_m[c] = d[7:0] & 8'h07;
				d = $random(seed);
				apb(1'b1, ra(c, 4'h5), d);
				rx_m[c] = d[7:0] & 8'h3f;
				d = $random(seed);
				apb(1'b1, ra(c, 4'h6), d);
				e3_m[c] = d[2];
			end
			analog_signal_loss_detector <= $random(seed);
			digital_signal_loss_detector <= $random(seed);
			txv <= $random(seed);
			rxv <= $random(seed);
			repeat (120) @(posedge clk);
			@(negedge tclk[0]);
			p1 = txp;
			@(negedge tclk[0]);
			p2 = txp;
			n2 = txn;
			@(posedge clk);
			for (int c = 0; c < 12; c++) begin
				if (tx_m[c][2]) begin
					chk_pin(p1[c] ^ p2[c], 1'b1, c);
					chk_pin(p2[c] ^ n2[c], 1'b1, c);
				end else begin
					chk_pin(p2[c], txv[c], c);
					chk_pin(n2[c], !txv[c], c);
				end
				chk_pin(los[c], los_exp(c), c);
				chk_pin(bld[c], tx_m[c][0] && !e3_m[c], c);
				chk_pin(eq[c], rx_m[c][0], c);
				chk_pin(rxpo[c], rxv[c] && !(rx_m[c][2] && los_exp(c)), c);
				chk_pin(rxno[c], !rxv[c] && !(rx_m[c][2] && los_exp(c)), c);
				apb(1'b0, ra(c, 4'h4), '0);
				chk_reg(rd, {24'h0, tx_m[c]});
				apb(1'b0, ra(c, 4'h5), '0);
				chk_reg(rd, {24'h0, rx_m[c]});
			end
		end
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, bad_a[i], 32'hffffffff);
			chk_reg({31'h0, er}, 32'h1);
			apb(1'b0, bad_a[i], '0);
			if (i < 4) chk_reg(rd, '0);
		end
		apb(1'b0, ra(5, 4'h5), '0);
		chk_reg(rd, {24'h0, rx_m[5]});
		apb(1'b0, ra(0, 4'h4), '0);
		chk_reg(rd, {24'h0, tx_m[0]});
		results();
	end
endmodule
